// ==== rtl/pcg_defs.vh ====
// Constants for the slot-to-controller host port glue block.
// Assumes inclusion by the single design file under rtl/.
`ifndef PCG_DEFS_VH
`define PCG_DEFS_VH

// ----------------------------------------------------------------------
// Strap field positions
// ----------------------------------------------------------------------
`define PCG_STRAP_W        16
`define PCG_WIDTH_BIT      0
`define PCG_BUSSEL_LO      1
`define PCG_BUSSEL_HI      3
`define PCG_ENDIAN_BIT     4
`define PCG_WAITPOL_BIT    5
`define PCG_STRAP_RESET    16'h0000

// ----------------------------------------------------------------------
// Bus select codes
// ----------------------------------------------------------------------
`define PCG_BUS_GENERIC    3'h3

// ----------------------------------------------------------------------
// Memory map
// ----------------------------------------------------------------------
`define PCG_MEM_SEL_BIT    21
`define PCG_REG_ALIAS_W    6
`define PCG_BUF_BASE       26'h0200000
`define PCG_BUF_LAST       26'h03FFFFF
`define PCG_ALIAS_W        4

// ----------------------------------------------------------------------
// Arbitration timing
// ----------------------------------------------------------------------
`define PCG_ARB_NS         200
`define PCG_CLK_NS         100
`define PCG_ARB_CYC        ((`PCG_ARB_NS + `PCG_CLK_NS - 1) / `PCG_CLK_NS)

`endif

// ==== rtl/pcg_host_glue.v ====
// Device-side host port of a display controller behind a 16-bit card slot.
// Assumes slot strobes are asynchronous pins and the glue decode is outside.
//
// Notes on behaviour
// - Sixteen strap pins latch on reset release and rule afterwards.
// - Width strap one means 8-bit port, zero means 16-bit.
// - Bus select 011 is generic; 000 to 010 processor; 1xx reserved.
// - Endian strap one means little endian, zero big endian.
// - Wait polarity strap one gives active-high wait, else active-low.
// - Registers from address zero; buffer from 200000h to 3fffffh.
// - Register set repeats every 64 bytes.
// - Address bits 25 to 22 ignored, so sixteen aliases appear.
// - Wait stays asserted until arbitration completes.
`include "pcg_defs.vh"

module pcg_host_glue #(
	parameter ARB_CYC = `PCG_ARB_CYC
) (
	// Clock and reset
	input  wire        clk_in,
	input  wire        srst_in,
	// Device pins after the glue decode
	input  wire        reset_n_in,
	input  wire        chip_sel_n_in,
	input  wire        low_byte_read_n_in,
	input  wire        high_byte_read_n_in,
	input  wire        low_byte_write_n_in,
	input  wire        high_byte_write_n_in,
	input  wire        bus_start_input_in,
	input  wire        mem_sel_in,
	input  wire [20:0] host_addr_in,
	input  wire [15:0] host_data_io_in,
	input  wire [15:0] strap_in,
	output wire [15:0] host_data_io_out,
	output wire        host_data_io_oe_out,
	output reg         wait_out,
	// Decoded configuration
	output wire        host_8bit_out,
	output wire [2:0]  bus_select_straps_out,
	output wire        generic_mode_out,
	output wire        bus_reserved_out,
	output wire        little_endian_out,
	output wire        wait_active_high_out,
	output wire [15:0] config_out,
	// Internal access port
	output reg         acc_valid_out,
	output reg         acc_write_out,
	output reg         acc_is_buf_out,
	output reg  [5:0]  acc_reg_idx_out,
	output reg  [20:0] acc_buf_addr_out,
	output reg  [1:0]  acc_lanes_out,
	output reg  [15:0] acc_wdata_out,
	input  wire [15:0] acc_rdata_in,
	input  wire        refresh_busy_in
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	localparam SW = 7;
	reg [SW-1:0] sa_q;
	reg [SW-1:0] sb_q;
	wire [SW-1:0] pins = {reset_n_in, chip_sel_n_in, low_byte_read_n_in,
		high_byte_read_n_in, low_byte_write_n_in, high_byte_write_n_in,
		bus_start_input_in};
	always @(posedge clk_in) begin
		if (srst_in) begin
			sa_q <= 7'h7F;
			sb_q <= 7'h7F;
		end else begin
			sa_q <= pins;
			sb_q <= sa_q;
		end
	end
	wire rst_n_s = sb_q[6];
	wire cs_s    = ~sb_q[5];
	wire rd0_s   = ~sb_q[4];
	wire rd1_s   = ~sb_q[3];
	wire wr0_s   = ~sb_q[2];
	wire wr1_s   = ~sb_q[1];

	// Address, data, space select: same two stages as the strobes
	reg [20:0] addr_s1_q;
	reg [20:0] addr_s2_q;
	reg [15:0] dat_s1_q;
	reg [15:0] dat_s2_q;
	reg        msel_s1_q;
	reg        msel_s2_q;
	always @(posedge clk_in) begin
		if (srst_in) begin
			addr_s1_q <= 21'h000000;
			addr_s2_q <= 21'h000000;
			dat_s1_q  <= 16'h0000;
			dat_s2_q  <= 16'h0000;
			msel_s1_q <= 1'b0;
			msel_s2_q <= 1'b0;
		end else begin
			addr_s1_q <= host_addr_in;
			addr_s2_q <= addr_s1_q;
			dat_s1_q  <= host_data_io_in;
			dat_s2_q  <= dat_s1_q;
			msel_s1_q <= mem_sel_in;
			msel_s2_q <= msel_s1_q;
		end
	end

	// ------------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------------
	reg        rst_n_d1_q;
	reg [15:0] strap_q;
	reg [15:0] strap_s1_q;
	reg [15:0] strap_s2_q;
	always @(posedge clk_in) begin
		if (srst_in) begin
			// Synced idle level, so no false edge after reset
			rst_n_d1_q <= 1'b1;
			strap_s1_q <= `PCG_STRAP_RESET;
			strap_s2_q <= `PCG_STRAP_RESET;
			strap_q    <= `PCG_STRAP_RESET;
		end else begin
			rst_n_d1_q <= rst_n_s;
			strap_s1_q <= strap_in;
			strap_s2_q <= strap_s1_q;
			// Straps held across the release, so the synced copy is safe
			if (rst_n_s && !rst_n_d1_q)
				strap_q <= strap_s2_q;
		end
	end
	assign config_out            = strap_q;
	assign host_8bit_out         = strap_q[`PCG_WIDTH_BIT];
	assign bus_select_straps_out =
		strap_q[`PCG_BUSSEL_HI:`PCG_BUSSEL_LO];
	assign bus_reserved_out      = strap_q[`PCG_BUSSEL_HI];
	assign generic_mode_out      =
		(bus_select_straps_out == `PCG_BUS_GENERIC);
	assign little_endian_out     = strap_q[`PCG_ENDIAN_BIT];
	assign wait_active_high_out  = strap_q[`PCG_WAITPOL_BIT];

	// ------------------------------------------------------------------
	// Access sequencer
	// ------------------------------------------------------------------
	localparam ST_IDLE = 3'h1;
	localparam ST_ARB  = 3'h2;
	localparam ST_DONE = 3'h4;
	reg [2:0]  st_q;
	reg [15:0] cnt_q;
	reg [15:0] rdata_q;
	reg        drive_q;
	wire rd_any  = rd0_s | rd1_s;
	wire wr_any  = wr0_s | wr1_s;
	// Unused lanes on 8-bit ports still decoded; host ignores high byte
	wire active  = rst_n_s && cs_s && generic_mode_out &&
		(rd_any || wr_any);
	wire is_buf  = msel_s2_q;
	wire [15:0] swap_in = little_endian_out ? dat_s2_q :
		{dat_s2_q[7:0], dat_s2_q[15:8]};
	wire wait_now = (st_q != ST_DONE) && active;

	always @(posedge clk_in) begin
		if (srst_in || !rst_n_s) begin
			st_q             <= ST_IDLE;
			cnt_q            <= 16'h0000;
			acc_valid_out    <= 1'b0;
			acc_write_out    <= 1'b0;
			acc_is_buf_out   <= 1'b0;
			acc_reg_idx_out  <= 6'h00;
			acc_buf_addr_out <= 21'h000000;
			acc_lanes_out    <= 2'h0;
			acc_wdata_out    <= 16'h0000;
			rdata_q          <= 16'h0000;
			drive_q          <= 1'b0;
			wait_out         <= 1'b0;
		end else begin
			acc_valid_out <= 1'b0;
			wait_out <= wait_now ^ ~wait_active_high_out;
			case (st_q)
			ST_IDLE: begin
				if (active) begin
					st_q             <= ST_ARB;
					cnt_q            <= 16'h0000;
					acc_write_out    <= wr_any;
					acc_is_buf_out   <= is_buf;
					// Upper slot bits never arrive here: aliases fall out
					acc_reg_idx_out  <=
						addr_s2_q[`PCG_REG_ALIAS_W-1:0];
					acc_buf_addr_out <= addr_s2_q;
					acc_lanes_out    <= {rd1_s | wr1_s,
						rd0_s | wr0_s};
					acc_wdata_out    <= swap_in;
				end
			end
			ST_ARB: begin
				if (!active) begin
					st_q <= ST_IDLE;
				end else if (!refresh_busy_in &&
						cnt_q >= ARB_CYC[15:0] - 16'h0001) begin
					st_q          <= ST_DONE;
					acc_valid_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
			ST_DONE: begin
				if (!acc_write_out) begin
					rdata_q <= little_endian_out ? acc_rdata_in :
						{acc_rdata_in[7:0], acc_rdata_in[15:8]};
					drive_q <= 1'b1;
				end
				if (!active) begin
					st_q    <= ST_IDLE;
					drive_q <= 1'b0;
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Read data only while a read strobe is still low
	assign host_data_io_out    = rdata_q;
	assign host_data_io_oe_out = drive_q && rd_any && cs_s;

endmodule

// ==== tb/pcg_host_glue_chk.sv ====
// Port checker for the device host port.
// Assumes one clock and a synchronous reset.
module pcg_host_glue_chk (
	input wire        clk_in,
	input wire        srst_in,
	input wire        wait_out,
	input wire        acc_valid_out,
	input wire        acc_is_buf_out,
	input wire [5:0]  acc_reg_idx_out,
	input wire [20:0] acc_buf_addr_out,
	input wire [20:0] host_addr_in,
	input wire [15:0] config_out,
	input wire        host_8bit_out,
	input wire [2:0]  bus_select_straps_out,
	input wire        generic_mode_out,
	input wire        bus_reserved_out,
	input wire        little_endian_out,
	input wire        wait_active_high_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	chk_width_decode: assert property (
		host_8bit_out == config_out[0])
		else $error("width decode");
	chk_bus_decode: assert property (
		bus_select_straps_out == config_out[3:1]
		&& generic_mode_out == (config_out[3:1] == 3'h3))
		else $error("bus decode");
	chk_endian_decode: assert property (
		little_endian_out == config_out[4])
		else $error("endian decode");
	chk_wait_pol: assert property (
		wait_active_high_out == config_out[5])
		else $error("wait polarity");
	chk_reg_alias: assert property (
		acc_valid_out && !acc_is_buf_out
		|-> acc_reg_idx_out == host_addr_in[5:0])
		else $error("register index");
	chk_buf_addr: assert property (
		acc_valid_out && acc_is_buf_out
		|-> acc_buf_addr_out == host_addr_in)
		else $error("buffer address");
	chk_wait_held: assert property (
		acc_valid_out |-> wait_out == wait_active_high_out)
		else $error("wait not held");
	chk_wait_release: assert property (
		acc_valid_out |=> wait_out != wait_active_high_out)
		else $error("wait not released");
	chk_valid_pulse: assert property (
		acc_valid_out |=> !acc_valid_out)
		else $error("valid too long");
	chk_mode_refuse: assert property (
		acc_valid_out |-> generic_mode_out && !bus_reserved_out)
		else $error("access in wrong mode");
	cov_reg: cover property (acc_valid_out && !acc_is_buf_out);
	cov_buf: cover property (acc_valid_out && acc_is_buf_out);
	cov_resv: cover property (bus_reserved_out);
endmodule

bind pcg_host_glue pcg_host_glue_chk chk (.*);

// ==== tb/pcg_slot_glue.sv ====
// Slot-side glue model: card strobes to device pins.
// Assumes active-low strobes and an active-high card reset.
module pcg_slot_glue (
	// Card side strobes
	input  wire oe_n_in,
	input  wire we_n_in,
	input  wire ce1_n_in,
	input  wire ce2_n_in,
	input  wire attr_n_in,
	input  wire card_rst_in,
	// Device side pins
	output wire reset_n_out,
	output wire cs_n_out,
	output wire bus_start_out,
	output wire rd0_n_out,
	output wire rd1_n_out,
	output wire wr0_n_out,
	output wire wr1_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Decode
	// ----
	// Attribute cycles blocked so config space never hits the device
	wire rd0 = !oe_n_in && !ce1_n_in && attr_n_in;
	wire rd1 = !oe_n_in && !ce2_n_in && attr_n_in;
	wire wr0 = !we_n_in && !ce1_n_in && attr_n_in;
	wire wr1 = !we_n_in && !ce2_n_in && attr_n_in;
	assign {rd0_n_out, rd1_n_out, wr0_n_out, wr1_n_out} = ~{rd0, rd1, wr0, wr1};
	// Upper address not decoded, so aliased copies are accepted
	assign cs_n_out = !(rd0 || rd1 || wr0 || wr1);
	assign reset_n_out = !card_rst_in;
	assign bus_start_out = 1'b0;
endmodule

// ==== tb/pcg_host_glue_tb.sv ====
// Bench for the device host port behind the slot glue model.
// Assumes the glue model and checker are compiled first.
module pcg_host_glue_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in = 0, srst_in = 1, busy = 0, msel = 0, crst = 1;
	logic        oe_n = 1, we_n = 1, ce1_n = 1, ce2_n = 1, attr_n = 1;
	logic [20:0] addr = 0;
	logic [15:0] din = 0, rdat = 0, strap = 16'h0016;
	wire         rst_n, cs_n, bs, r0n, r1n, w0n, w1n, doe, av, aw, ab, wt;
	wire  [15:0] dout, cfg, wd;
	wire  [5:0]  ri;
	wire  [20:0] ba;
	wire  [1:0]  ln;
	int          err_total = 0, tests_run = 0;
	logic [40:0] q[$];
	// ----
	// Clock, glue and device
	// ----
	// Free-running host clock; the tasks change the slot strobes on its rising edge
	initial forever #50 clk_in = !clk_in;
	// Random refresh load stretches arbitration
	always @(posedge clk_in) busy <= ($urandom % 4) == 0;
	pcg_slot_glue glue (.oe_n_in(oe_n), .we_n_in(we_n), .ce1_n_in(ce1_n),
		.ce2_n_in(ce2_n), .attr_n_in(attr_n), .card_rst_in(crst),
		.reset_n_out(rst_n), .cs_n_out(cs_n), .bus_start_out(bs),
		.rd0_n_out(r0n), .rd1_n_out(r1n), .wr0_n_out(w0n), .wr1_n_out(w1n));
	pcg_host_glue dut (.clk_in(clk_in), .srst_in(srst_in),
		.reset_n_in(rst_n), .chip_sel_n_in(cs_n), .low_byte_read_n_in(r0n),
		.high_byte_read_n_in(r1n), .low_byte_write_n_in(w0n),
		.high_byte_write_n_in(w1n), .bus_start_input_in(bs),
		.mem_sel_in(msel), .host_addr_in(addr), .host_data_io_in(din),
		.strap_in(strap), .host_data_io_out(dout), .host_data_io_oe_out(doe),
		.wait_out(wt), .host_8bit_out(), .bus_select_straps_out(),
		.generic_mode_out(), .bus_reserved_out(), .little_endian_out(),
		.wait_active_high_out(), .config_out(cfg), .acc_valid_out(av),
		.acc_write_out(aw), .acc_is_buf_out(ab), .acc_reg_idx_out(ri),
		.acc_buf_addr_out(ba), .acc_lanes_out(ln), .acc_wdata_out(wd),
		.acc_rdata_in(rdat), .refresh_busy_in(busy));
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic card_reset(input logic [15:0] s);
		@(posedge clk_in);
		strap <= s;
		crst <= 1;
		repeat (3) @(posedge clk_in);
		crst <= 0;
		repeat (6) @(negedge clk_in);
		chk(cfg === s, "config");
	endtask
	task automatic access(input logic e, w, m, input logic [1:0] l,
		input logic [20:0] a, input logic [15:0] d);
		int n;
		logic [40:0] x;
		logic [15:0] k, kw, ws, rs;
		logic le;
		k = {{8{l[1]}}, {8{l[0]}}};
		le = strap[4];
		kw = le ? k : {k[7:0], k[15:8]};
		ws = le ? d : {d[7:0], d[15:8]};
		if (e) q.push_back({w, m, l, a, d});
		@(posedge clk_in);
		{addr, msel, din, rdat} <= {a, m, d, 16'($urandom)};
		{oe_n, we_n, ce1_n, ce2_n} <= {w, !w, !l[0], !l[1]};
		for (n = 0; n < (e ? 60 : 12) && av !== 1'b1; n++) @(negedge clk_in);
		chk(av === e, "access taken");
		if (e && av !== 1'b1) end_of_test;
		if (av === 1'b1) begin
			x = q.pop_front();
			chk({aw, ab, ln} === x[40:37], "kind or lanes");
			chk(ab ? ba === a : ri === a[5:0], "address");
			chk(!w || ((wd ^ ws) & kw) === 16'h0000, "write data");
			chk(wt === strap[5], "wait held");
			for (n = 0; n < 10 && !w && doe !== 1'b1; n++) @(negedge clk_in);
			if (w) @(negedge clk_in);
			rs = le ? rdat : {rdat[7:0], rdat[15:8]};
			chk(doe === !w, "data drive");
			chk(w || ((dout ^ rs) & k) === 16'h0000, "read data");
			chk(wt === !strap[5], "wait released");
		end else chk(wt === !strap[5], "wait idle");
		@(posedge clk_in);
		{oe_n, we_n, ce1_n, ce2_n} <= 4'hF;
		repeat (4) @(posedge clk_in);
	endtask
	initial begin
		void'($urandom(32'hEAD700DC));
		repeat (8) @(posedge clk_in);
		srst_in <= 0;
		card_reset(16'h0016);
		for (int i = 0; i < 10; i++)
			access(1, 1'($urandom), 1'($urandom), 2'(1 + $urandom % 3),
				21'($urandom), 16'($urandom));
		attr_n <= 0;
		access(0, 0, 0, 2'h3, 21'h000004, 16'h1234);
		attr_n <= 1;
		card_reset(16'h0026);
		for (int i = 0; i < 6; i++)
			access(1, 1'($urandom), 1'($urandom), 2'(1 + $urandom % 3),
				21'($urandom), 16'($urandom));
		card_reset(16'h0008);
		access(0, 1, 0, 2'h3, 21'h000040, 16'hA5A5);
		end_of_test;
	end
endmodule
